//--- rtl/mnx_cfg.svh
// Opcodes, cycle counts and flag positions of the multiply, dispatch and idle unit
`ifndef MNX_CFG_SVH
`define MNX_CFG_SVH
`define MNX_OP_MUL_IND 8'h85
`define MNX_OP_MUL_IMM 8'h86
`define MNX_OP_NEXT 8'h0f
`define MNX_OP_IDLE 8'hff
`define MNX_CYC_MUL 5'd22
`define MNX_CYC_NEXT 5'd10
`define MNX_CYC_IDLE 5'd4
`define MNX_POINTER_STEP 16'h0002
`define MNX_FLAG_Z 2
`define MNX_FLAG_S 1
`define MNX_FLAG_V 0
`endif

//--- rtl/mnx_pkg.sv
// Types shared by the multiply, dispatch and idle unit
package mnx_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MUL = 4'b0010,
        ST_NEXT = 4'b0100,
        ST_WAIT = 4'b1000
    } mnx_state_type;
endpackage : mnx_pkg

//--- rtl/mnx_mul8.sv
// Registered unsigned 8x8 multiplier
`timescale 1ns/1ps
module mnx_mul8 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Operands and product
    input wire logic [WIDTH-1:0] opa,
    input wire logic [WIDTH-1:0] opb,
    output logic [2*WIDTH-1:0] product_q
);
    // Both operands are zero-extended, so the product is purely unsigned
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            product_q <= '0;
        else
            product_q <= {{WIDTH{1'b0}}, opa} * {{WIDTH{1'b0}}, opb};
    end
endmodule : mnx_mul8

//--- rtl/mnx_exec.sv
// Execute unit for unsigned multiply, threaded dispatch and idle instructions
// How it works
// - Opcodes 85/86 multiply; 16-bit product to pair, high byte even, 22 cycles.
// - Opcode 0F, 10 cycles, loads program counter from word at instruction pointer.
// - After that load the instruction pointer advances by two.
// - Dispatch and idle instructions leave all condition flags unchanged.
// - Opcode FF changes nothing and only spends 4 cycles.
// - Multiply treats even destination byte and source byte as unsigned.
// - Multiply sets zero and sign from result and clears overflow.
`timescale 1ns/1ps
`include "mnx_cfg.svh"
module mnx_exec
    import mnx_pkg::*;
#(
    parameter int FLAGW = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Instruction issue
    input wire logic start,
    input wire logic [7:0] opcode,
    // Operands: even destination byte, indirect and immediate source
    input wire logic [7:0] dst_hi,
    input wire logic [7:0] src_ind,
    input wire logic [7:0] src_imm,
    // Pointer, program counter, flags and program memory word at the instruction pointer
    input wire logic [15:0] instruction_pointer_in,
    input wire logic [15:0] program_counter_in,
    input wire logic [15:0] pmem_word,
    input wire logic [FLAGW-1:0] flags_in,
    // Results
    output logic busy_q,
    output logic done_q,
    output logic pair_we_q,
    output logic [7:0] pair_hi_q,
    output logic [7:0] pair_lo_q,
    output logic [15:0] pmem_addr_q,
    output logic [15:0] program_counter_q,
    output logic [15:0] instruction_pointer_q,
    output logic regs_we_q,
    output logic [FLAGW-1:0] flags_q
);
    mnx_state_type state_q;
    logic [4:0] cnt_q;
    logic [7:0] mul_src_q;
    logic [7:0] mul_dst_q;
    logic [15:0] product;
    logic finish;

    assign finish = (state_q != ST_IDLE) && (cnt_q == 5'd1);

    mnx_mul8 #(.WIDTH(8)) i_mnx_mul8 (
        .mclk(mclk),
        .reset_n(reset_n),
        .opa(mul_dst_q),
        .opb(mul_src_q),
        .product_q(product)
    );

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            mul_src_q <= 8'h00;
            mul_dst_q <= 8'h00;
        end
        else if (start && state_q == ST_IDLE)
        begin
            mul_dst_q <= dst_hi;
            mul_src_q <= (opcode == `MNX_OP_MUL_IMM) ? src_imm : src_ind;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'd0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        // Unknown opcodes are left to the rest of the core
                        if (opcode == `MNX_OP_MUL_IND || opcode == `MNX_OP_MUL_IMM)
                        begin
                            state_q <= ST_MUL;
                            cnt_q <= `MNX_CYC_MUL;
                        end
                        else if (opcode == `MNX_OP_NEXT)
                        begin
                            state_q <= ST_NEXT;
                            cnt_q <= `MNX_CYC_NEXT;
                        end
                        else if (opcode == `MNX_OP_IDLE)
                        begin
                            state_q <= ST_WAIT;
                            cnt_q <= `MNX_CYC_IDLE;
                        end
                    end
                end
                ST_MUL, ST_NEXT, ST_WAIT:
                begin
                    cnt_q <= cnt_q - 5'd1;
                    if (finish)
                        state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    cnt_q <= 5'd0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= finish;
            busy_q <= (state_q == ST_IDLE) ? (start && (opcode == `MNX_OP_MUL_IND
                || opcode == `MNX_OP_MUL_IMM || opcode == `MNX_OP_NEXT
                || opcode == `MNX_OP_IDLE)) : !finish;
        end
    end

    // product written to pair on completion
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pair_we_q <= 1'b0;
            pair_hi_q <= 8'h00;
            pair_lo_q <= 8'h00;
        end
        else
        begin
            pair_we_q <= finish && state_q == ST_MUL;
            if (finish && state_q == ST_MUL)
            begin
                pair_hi_q <= product[15:8];
                pair_lo_q <= product[7:0];
            end
        end
    end

    // other instructions pass flags through untouched
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            flags_q <= '0;
        else if (finish && state_q == ST_MUL)
        begin
            flags_q <= flags_in;
            flags_q[`MNX_FLAG_Z] <= (product == 16'h0000);
            flags_q[`MNX_FLAG_S] <= product[15];
            flags_q[`MNX_FLAG_V] <= 1'b0;
        end
        else
            flags_q <= flags_in;
    end

    // fetch address and program counter load
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pmem_addr_q <= 16'h0000;
            program_counter_q <= 16'h0000;
            instruction_pointer_q <= 16'h0000;
            regs_we_q <= 1'b0;
        end
        else
        begin
            regs_we_q <= finish && state_q == ST_NEXT;
            if (start && state_q == ST_IDLE && opcode == `MNX_OP_NEXT)
                pmem_addr_q <= instruction_pointer_in;
            if (finish && state_q == ST_NEXT)
            begin
                program_counter_q <= pmem_word;
                instruction_pointer_q <= pmem_addr_q + `MNX_POINTER_STEP;
            end
            else if (state_q == ST_IDLE)
            begin
                program_counter_q <= program_counter_in;
                instruction_pointer_q <= instruction_pointer_in;
            end
        end
    end

    // Assertions
    logic [4:0] span_q;
    always_ff @(posedge mclk)
    begin
        if (!reset_n || state_q == ST_IDLE)
            span_q <= 5'd0;
        else
            span_q <= span_q + 5'd1;
    end

    chk_mul_length: assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && state_q == ST_MUL) |-> span_q == 5'd21)
        else $error("multiply length wrong");
    chk_next_length: assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && state_q == ST_NEXT) |-> span_q == 5'd9)
        else $error("dispatch length wrong");
    chk_next_counter: assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && state_q == ST_NEXT) |=> program_counter_q == $past(pmem_word))
        else $error("program counter not loaded");
    chk_pointer_step: assert property (@(posedge mclk) disable iff (!reset_n)
        regs_we_q |-> instruction_pointer_q == pmem_addr_q + 16'h0002)
        else $error("pointer not advanced by two");
    chk_flags_kept: assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && state_q != ST_MUL) |=> flags_q == $past(flags_in))
        else $error("flags changed");
    chk_idle_length: assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && state_q == ST_WAIT) |-> span_q == 5'd3 ##1 !pair_we_q && !regs_we_q)
        else $error("idle wrong");
    chk_mul_value: assert property (@(posedge mclk) disable iff (!reset_n)
        pair_we_q |-> {pair_hi_q, pair_lo_q} == 16'(mul_dst_q) * 16'(mul_src_q))
        else $error("product wrong");
    chk_mul_flags: assert property (@(posedge mclk) disable iff (!reset_n)
        pair_we_q |-> flags_q[2] == ({pair_hi_q, pair_lo_q} == 16'h0000)
        && flags_q[1] == pair_hi_q[7] && !flags_q[0])
        else $error("multiply flags wrong");

    cov_mul: cover property (@(posedge mclk) pair_we_q);
    cov_next: cover property (@(posedge mclk) regs_we_q);
    cov_idle: cover property (@(posedge mclk) finish && state_q == ST_WAIT);
endmodule : mnx_exec

//--- testbench/test_mnx_exec.sv
// Self-checking bench for the multiply, dispatch and idle execute unit
`timescale 1ns/1ps
`include "mnx_cfg.svh"
`define TB_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module test_mnx_exec;
    typedef struct {
        logic [7:0] op, dst, ind, imm;
        logic [2:0] fl, efl;
        logic [15:0] prod;
        logic [4:0] n;
    } mnx_row_type;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] opcode = 8'h00, dst_hi = 8'h00, src_ind = 8'h00, src_imm = 8'h00;
    logic [15:0] instruction_pointer_in = 16'h0000;
    logic [15:0] program_counter_in = 16'h0000;
    logic [15:0] pmem_word = 16'h0000;
    logic [2:0] flags_in = 3'b000;
    logic busy_q, done_q, pair_we_q, regs_we_q;
    logic [7:0] pair_hi_q, pair_lo_q, last_hi, last_lo;
    logic [15:0] pmem_addr_q, program_counter_q, instruction_pointer_q;
    logic [2:0] flags_q;
    int n_fail = 0;
    int comparisons = 0;
    int cnt;
    mnx_row_type bad;
    // Source choice is exposed by giving the unused source a different byte
    mnx_row_type rows [6] = '{
        '{`MNX_OP_MUL_IMM, 8'h20, 8'h55, 8'h09, 3'b001, 3'b000, 16'h0120, `MNX_CYC_MUL},
        '{`MNX_OP_MUL_IND, 8'hff, 8'hff, 8'h03, 3'b101, 3'b010, 16'hfe01, `MNX_CYC_MUL},
        '{`MNX_OP_IDLE, 8'h11, 8'h22, 8'h33, 3'b110, 3'b110, 16'h0000, `MNX_CYC_IDLE},
        '{`MNX_OP_MUL_IND, 8'h00, 8'h7b, 8'hff, 3'b011, 3'b100, 16'h0000, `MNX_CYC_MUL},
        '{`MNX_OP_NEXT, 8'h40, 8'hcd, 8'h10, 3'b011, 3'b011, 16'h0000, `MNX_CYC_NEXT},
        '{`MNX_OP_MUL_IMM, 8'h80, 8'hff, 8'h03, 3'b111, 3'b000, 16'h0180, `MNX_CYC_MUL}};

    mnx_exec #(.FLAGW(3)) i_mnx_exec (.mclk(mclk), .reset_n(reset_n), .start(start),
        .opcode(opcode), .dst_hi(dst_hi), .src_ind(src_ind), .src_imm(src_imm),
        .instruction_pointer_in(instruction_pointer_in),
        .program_counter_in(program_counter_in), .pmem_word(pmem_word), .flags_in(flags_in),
        .busy_q(busy_q), .done_q(done_q), .pair_we_q(pair_we_q), .pair_hi_q(pair_hi_q),
        .pair_lo_q(pair_lo_q), .pmem_addr_q(pmem_addr_q),
        .program_counter_q(program_counter_q),
        .instruction_pointer_q(instruction_pointer_q), .regs_we_q(regs_we_q),
        .flags_q(flags_q));

    always #12.5 mclk = ~mclk;

    task summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // Called at a rising edge; returns at the edge that takes the request
    task go(input mnx_row_type r);
        start <= 1'b1;
        opcode <= r.op;
        dst_hi <= r.dst;
        src_ind <= r.ind;
        src_imm <= r.imm;
        flags_in <= r.fl;
        instruction_pointer_in <= {r.dst, r.imm};
        program_counter_in <= {r.ind, r.dst};
        pmem_word <= {r.imm, r.ind};
        @(posedge mclk);
        start <= 1'b0;
    endtask : go

    // Sampling at the edge sees the done pulse one edge after it was set
    task wait_done(input logic [4:0] n);
        cnt = 0;
        do
        begin
            @(posedge mclk);
            cnt++;
            if (cnt == 1) `TB_CHK(busy_q, 1'b1)
        end
        while (done_q !== 1'b1 && cnt < 40);
        if (done_q !== 1'b1)
        begin
            n_fail++;
            summarize();
        end
        `TB_CHK(cnt, n + 1)
    endtask : wait_done

    task check_row(input mnx_row_type r);
        `TB_CHK(flags_q, r.efl)
        if (r.op == `MNX_OP_NEXT)
        begin
            `TB_CHK({pair_we_q, regs_we_q}, 2'b01)
            `TB_CHK(pmem_addr_q, {r.dst, r.imm})
            `TB_CHK(program_counter_q, {r.imm, r.ind})
            `TB_CHK(instruction_pointer_q, {r.dst, r.imm} + `MNX_POINTER_STEP)
        end
        else if (r.op == `MNX_OP_IDLE)
        begin
            `TB_CHK({pair_we_q, regs_we_q}, 2'b00)
            `TB_CHK({pair_hi_q, pair_lo_q}, {last_hi, last_lo})
            `TB_CHK(instruction_pointer_q, {r.dst, r.imm})
            `TB_CHK(program_counter_q, {r.ind, r.dst})
        end
        else
        begin
            `TB_CHK({pair_we_q, regs_we_q}, 2'b10)
            `TB_CHK({pair_hi_q, pair_lo_q}, r.prod)
            last_hi = r.prod[15:8];
            last_lo = r.prod[7:0];
        end
    endtask : check_row

    initial
    begin
        repeat (8) @(posedge mclk);
        `TB_CHK({busy_q, done_q, pair_we_q, regs_we_q, flags_q}, 7'h00)
        `TB_CHK(program_counter_q, 16'h0000)
        reset_n <= 1'b1;
        @(posedge mclk);
        foreach (rows[i])
        begin
            go(rows[i]);
            wait_done(rows[i].n);
            check_row(rows[i]);
        end
        // Next request lands in the cycle that shows done
        go(rows[2]);
        repeat (4) @(posedge mclk);
        go(rows[0]);
        `TB_CHK(done_q, 1'b1)
        wait_done(rows[0].n);
        check_row(rows[0]);
        // A request while busy must not disturb the running multiply
        go(rows[5]);
        repeat (2) @(posedge mclk);
        go(rows[2]);
        // Three edges of the multiply have already passed here
        wait_done(`MNX_CYC_MUL - 5'd3);
        check_row(rows[5]);
        // Unknown opcodes start nothing
        bad = rows[2];
        bad.op = 8'h00;
        go(bad);
        // Watch past the longest budget so a wrongly taken opcode shows up
        repeat (24)
        begin
            @(posedge mclk);
            `TB_CHK({busy_q, done_q}, 2'b00)
        end
        // Reset in mid-run drops the product
        go(rows[1]);
        repeat (3) @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (30) @(posedge mclk);
        `TB_CHK({pair_hi_q, pair_lo_q, busy_q}, 17'h00000)
        summarize();
    end
endmodule : test_mnx_exec
